//--- logic/plsc_bit_rx.sv
// receive bit recovery: pin synchronisers, phase tracking and nrzi decode
`timescale 1ns/1ps
`default_nettype none
module plsc_bit_rx
  import plsc_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic test_mode,
  input  wire logic serial_in,
  input  wire logic rx_ext_bit_clk,
  output logic      bit_stb,
  output logic      bit_val
);

  typedef struct packed {
    logic       s_meta;
    logic       s_sync;
    logic       s_prev;
    logic       c_meta;
    logic       c_sync;
    logic       c_prev;
    logic [3:0] phase;
    logic       lvl;
    logic       stb;
    logic       val;
  } plsc_brx_t;

  plsc_brx_t st_r;
  plsc_brx_t st_nxt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.s_meta = serial_in;
    st_nxt.s_sync = st_r.s_meta;
    st_nxt.s_prev = st_r.s_sync;
    st_nxt.c_meta = rx_ext_bit_clk;
    st_nxt.c_sync = st_r.c_meta;
    st_nxt.c_prev = st_r.c_sync;
    st_nxt.stb    = 1'b0;
    if (test_mode) begin
      // external tracking loop supplies the sample instant [R9]
      st_nxt.phase = ZERO4;
      if (st_r.c_sync && !st_r.c_prev) begin
        st_nxt.stb = 1'b1;
        st_nxt.val = st_r.s_sync ^ st_r.lvl;
        st_nxt.lvl = st_r.s_sync;
      end
    end else begin
      // each line transition re-centres the sample point [R10]
      if (st_r.s_sync != st_r.s_prev) begin
        st_nxt.phase = 4'h1;
      end else if (st_r.phase == BIT_LAST) begin
        st_nxt.phase = ZERO4;
      end else begin
        st_nxt.phase = st_r.phase + 4'h1;
      end
      if (st_r.phase == BIT_SAMPLE) begin
        // a change of level is a one, no change a zero [R14]
        st_nxt.stb = 1'b1;
        st_nxt.val = st_r.s_sync ^ st_r.lvl;
        st_nxt.lvl = st_r.s_sync;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bit_stb = st_r.stb;
  assign bit_val = st_r.val;

endmodule : plsc_bit_rx
`default_nettype wire

//--- logic/plsc_link_codec.sv
// parallel/serial link codec: block-coded nrzi transmitter and sync-framed receiver
//
// Contract
// [R1] eight-bit width: each nibble maps separately to a five-bit symbol.
// [R2] the coded word leaves as an nrzi serial stream.
// [R3] twelve lines split 8+4, 9+3 or 10+2 data plus command by width.
// [R4] host raises the load strobe; transmitter acknowledges once the word is taken.
// [R5] receiver pulses its output strobe when a new word is on its outputs.
// [R6] strobed byte periods carry the word; all others carry sync; at nine and ten bits the first period after reset carries TX_SH_RST instead.
// [R7] received sync leaves the output latch alone and raises no strobe.
// [R8] receiver finds and keeps byte boundaries from the sync pattern.
// [R9] test mode takes bit timing from outside instead of internal loops.
// [R10] receiver recovers bit timing from transitions, shifts in and decodes.
// [R11] any nonzero command bit sends a command symbol, ignoring data.
// [R12] nine-bit uses a six-bit upper group; ten-bit uses two six-bit groups.
// [R13] serial order is msb of upper group first down to lsb of lower.
// [R14] a coded one toggles the line, a coded zero holds it.
// [R15] exactly one symbol goes out per byte period.
`timescale 1ns/1ps
`default_nettype none
module plsc_link_codec
  import plsc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [1:0] width_sel,
  input  wire logic       test_mode,
  input  wire logic       tx_ext_bit_clk,
  input  wire logic       rx_ext_bit_clk,
  input  wire logic [9:0] data_in,
  input  wire logic [3:0] cmd_in,
  input  wire logic       word_load_strobe,
  output logic            word_ack,
  output logic            serial_out,
  input  wire logic       serial_in,
  output logic [9:0]      data_out,
  output logic [3:0]      cmd_out,
  output logic            word_out_strobe,
  output logic            word_out_is_cmd,
  output logic            rx_aligned
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]     wsel_meta;
    logic [1:0]     wsel;
    logic           test_meta;
    logic           test;
    logic           tclk_meta;
    logic           tclk;
    logic           tclk_prev;
    logic [3:0]     bit_div;
    logic           latch_full;
    logic           taken;
    logic [9:0]     lat_data;
    logic [3:0]     lat_cmd;
    logic           ack;
    logic [11:0]    tx_sh;
    logic [3:0]     tx_cnt;
    logic           line;
    plsc_rx_state_t rx_st;
    logic [11:0]    rx_sh;
    logic [3:0]     rx_cnt;
    logic [9:0]     dout;
    logic [3:0]     cout;
    logic           ostb;
    logic           ocmd;
  } plsc_core_t;

  plsc_core_t st_r;
  plsc_core_t st_nxt;

  logic        rx_bit_stb;
  logic        rx_bit_val;
  plsc_width_t width;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic plsc_width_t to_width(input logic [1:0] w);
    plsc_width_t r;
    case (w)
      2'b00:   r = PLSC_W8;
      2'b01:   r = PLSC_W9;
      default: r = PLSC_W10;
    endcase
    return r;
  endfunction : to_width

  function automatic logic [3:0] sym_len(input plsc_width_t w);
    logic [3:0] n;
    case (w)
      PLSC_W8: n = LEN_W8;
      PLSC_W9: n = LEN_W9;
      default: n = LEN_W10;
    endcase
    return n;
  endfunction : sym_len

  // command and sync groups carry a zero in the extra six-bit position
  function automatic logic [11:0] widen(input logic [9:0] s, input plsc_width_t w);
    logic [11:0] r;
    case (w)
      PLSC_W8: r = {2'b00, s};
      PLSC_W9: r = {2'b00, s};
      default: r = {1'b0, s[9:5], 1'b0, s[4:0]};
    endcase
    return r;
  endfunction : widen

  // coded word, right justified in twelve bits
  function automatic logic [11:0] encode(input logic [9:0] d, input logic [3:0] c,
                                         input plsc_width_t w);
    logic [11:0] r;
    logic [3:0]  cm;
    r  = ZERO12;
    cm = ZERO4;
    case (w)                                                   // [R3]
      PLSC_W8: cm = c;
      PLSC_W9: cm = {1'b0, c[2:0]};
      default: cm = {2'b00, c[1:0]};
    endcase
    if (cm != ZERO4) begin
      r = widen(plsc_cmd_sym(cm), w);                          // [R11]
    end else begin
      case (w)
        PLSC_W8: r = {2'b00, plsc_enc4(d[7:4]), plsc_enc4(d[3:0])};         // [R1]
        PLSC_W9: r = {1'b0, d[8], plsc_enc4(d[7:4]), plsc_enc4(d[3:0])};     // [R12]
        default: r = {d[8], plsc_enc4(d[7:4]), d[9], plsc_enc4(d[3:0])};     // [R12]
      endcase
    end
    return r;
  endfunction : encode

  function automatic logic [11:0] len_mask(input plsc_width_t w);
    logic [11:0] m;
    case (w)
      PLSC_W8: m = 12'h3ff;
      PLSC_W9: m = 12'h7ff;
      default: m = 12'hfff;
    endcase
    return m;
  endfunction : len_mask

  // five-bit data symbol back to a nibble; ok low for non-data symbols
  function automatic logic [4:0] dec5(input logic [4:0] s);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (plsc_enc4(4'(i)) == s) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : dec5

  // ---------------------------------------------------------------
  // bit recovery
  // ---------------------------------------------------------------
  plsc_bit_rx u_bit_rx (
    .clk            (clk),
    .reset          (reset),
    .test_mode      (st_r.test),
    .serial_in      (serial_in),
    .rx_ext_bit_clk (rx_ext_bit_clk),
    .bit_stb        (rx_bit_stb),
    .bit_val        (rx_bit_val)
  );

  assign width = to_width(st_r.wsel);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic        tick;
    logic        sbit;
    logic [11:0] code;
    logic [11:0] sh_n;
    logic [3:0]  n;
    logic [4:0]  hi_d;
    logic [4:0]  lo_d;
    logic        hx;
    logic        lx;
    logic [9:0]  sym10;
    logic [3:0]  kmatch;
    tick   = 1'b0;
    sbit   = 1'b0;
    code   = ZERO12;
    sh_n   = ZERO12;
    n      = sym_len(width);
    hi_d   = 5'h00;
    lo_d   = 5'h00;
    hx     = 1'b0;
    lx     = 1'b0;
    sym10  = ZERO10;
    kmatch = ZERO4;

    st_nxt           = st_r;
    // mode straps come from pins, so they pass two flops first
    st_nxt.wsel_meta = width_sel;
    st_nxt.wsel      = st_r.wsel_meta;
    st_nxt.test_meta = test_mode;
    st_nxt.test      = st_r.test_meta;
    st_nxt.tclk_meta = tx_ext_bit_clk;
    st_nxt.tclk      = st_r.tclk_meta;
    st_nxt.tclk_prev = st_r.tclk;
    st_nxt.ack       = 1'b0;
    st_nxt.ostb      = 1'b0;

    // input latch: one word per strobe, strobe must fall before the next
    if (!word_load_strobe) begin
      st_nxt.taken = 1'b0;
    end
    if (word_load_strobe && !st_r.taken && !st_r.latch_full) begin   // [R4]
      st_nxt.latch_full = 1'b1;
      st_nxt.taken      = 1'b1;
      st_nxt.lat_data   = data_in;
      st_nxt.lat_cmd    = cmd_in;
      st_nxt.ack        = 1'b1;
    end

    // bit timing: internal divider, or external clock in test mode
    if (st_r.test) begin
      st_nxt.bit_div = ZERO4;
      tick = st_r.tclk && !st_r.tclk_prev;                      // [R9]
    end else if (st_r.bit_div == BIT_LAST) begin
      st_nxt.bit_div = ZERO4;
      tick = 1'b1;
    end else begin
      st_nxt.bit_div = st_r.bit_div + 4'h1;
    end

    // transmit shifter, left justified so the msb leaves first
    if (tick) begin
      sbit         = st_r.tx_sh[11];                            // [R13]
      st_nxt.line  = st_r.line ^ sbit;                          // [R2] [R14]
      st_nxt.tx_sh = {st_r.tx_sh[10:0], 1'b0};
      if (st_r.tx_cnt >= n - 4'h1) begin
        // byte boundary: the held word if strobed, else sync [R15]
        st_nxt.tx_cnt = ZERO4;
        if (st_r.latch_full) begin
          code              = encode(st_r.lat_data, st_r.lat_cmd, width);
          st_nxt.latch_full = 1'b0;                             // [R6]
        end else begin
          code = widen(SYNC_SYM, width);                        // [R6]
        end
        st_nxt.tx_sh = code << (4'hc - n);
      end else begin
        st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
      end
    end

    // receive framer and decoder
    if (rx_bit_stb) begin
      sh_n         = {st_r.rx_sh[10:0], rx_bit_val};            // [R10]
      st_nxt.rx_sh = sh_n;
      case (width)
        PLSC_W8: begin
          hx    = 1'b0;
          lx    = 1'b0;
          sym10 = sh_n[9:0];
        end
        PLSC_W9: begin
          hx    = sh_n[10];
          lx    = 1'b0;
          sym10 = sh_n[9:0];
        end
        default: begin
          hx    = sh_n[11];
          lx    = sh_n[5];
          sym10 = {sh_n[10:6], sh_n[4:0]};
        end
      endcase
      hi_d = dec5(sym10[9:5]);
      lo_d = dec5(sym10[4:0]);
      for (int k = 1; k < 16; k++) begin
        if (plsc_cmd_sym(4'(k)) == sym10) begin
          kmatch = 4'(k);
        end
      end
      if ((sh_n & len_mask(width)) == widen(SYNC_SYM, width)) begin
        // sync fixes the boundary and leaves the output latch alone
        st_nxt.rx_st  = RX_ALIGNED;                             // [R8]
        st_nxt.rx_cnt = ZERO4;                                  // [R7]
      end else if (st_r.rx_st == RX_ALIGNED) begin
        if (st_r.rx_cnt >= n - 4'h1) begin
          st_nxt.rx_cnt = ZERO4;
          if (hi_d[4] && lo_d[4]) begin
            st_nxt.dout = ZERO10;
            st_nxt.dout[7:0] = {hi_d[3:0], lo_d[3:0]};
            if (width != PLSC_W8) begin
              st_nxt.dout[8] = hx;
            end
            if (width == PLSC_W10) begin
              st_nxt.dout[9] = lx;
            end
            st_nxt.cout = ZERO4;
            st_nxt.ostb = 1'b1;                                 // [R5]
            st_nxt.ocmd = 1'b0;
          end else if (kmatch != ZERO4 && !hx && !lx) begin
            st_nxt.cout = kmatch;                               // [R3]
            st_nxt.ostb = 1'b1;                                 // [R5]
            st_nxt.ocmd = 1'b1;
          end else begin
            // a code violation means the boundary is lost; hunt again
            st_nxt.rx_st = RX_HUNT;
          end
        end else begin
          st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r       <= '0;
      st_r.tx_sh <= TX_SH_RST;
      st_r.line  <= LINE_RST;
      st_r.rx_st <= RX_HUNT;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign word_ack        = st_r.ack;
  assign serial_out      = st_r.line;
  assign data_out        = st_r.dout;
  assign cmd_out         = st_r.cout;
  assign word_out_strobe = st_r.ostb;
  assign word_out_is_cmd = st_r.ocmd;
  assign rx_aligned      = (st_r.rx_st == RX_ALIGNED);

endmodule : plsc_link_codec
`default_nettype wire

//--- logic/plsc_pkg.sv
// shared constants, types and code tables of the parallel/serial link codec
package plsc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned BIT_TIME_NS   = 100;
  // whole clocks per serial bit, at least one
  localparam int unsigned BIT_CYC_INT   = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  BIT_CYCLES    = 4'(BIT_CYC_INT);
  localparam logic [3:0]  BIT_LAST      = 4'(BIT_CYC_INT - 1);
  localparam logic [3:0]  BIT_SAMPLE    = 4'(BIT_CYC_INT / 2);

  // ---------------------------------------------------------------
  // widths and symbol lengths
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PLSC_W8  = 2'b00,
    PLSC_W9  = 2'b01,
    PLSC_W10 = 2'b10
  } plsc_width_t;

  localparam logic [3:0] LEN_W8  = 4'ha;
  localparam logic [3:0] LEN_W9  = 4'hb;
  localparam logic [3:0] LEN_W10 = 4'hc;

  typedef enum logic [1:0] {
    RX_HUNT    = 2'b00,
    RX_ALIGNED = 2'b01
  } plsc_rx_state_t;

  // ---------------------------------------------------------------
  // symbols and reset values
  // ---------------------------------------------------------------
  localparam logic [9:0]  SYNC_SYM   = 10'h311;
  localparam logic [11:0] TX_SH_RST  = 12'hc44;
  localparam logic [3:0]  ZERO4      = 4'h0;
  localparam logic [9:0]  ZERO10     = 10'h000;
  localparam logic [11:0] ZERO12     = 12'h000;
  localparam logic        LINE_RST   = 1'b0;

  // nibble to five-bit data symbol
  function automatic logic [4:0] plsc_enc4(input logic [3:0] v);
    logic [4:0] s;
    case (v)
      4'h0: s = 5'h1e;
      4'h1: s = 5'h09;
      4'h2: s = 5'h14;
      4'h3: s = 5'h15;
      4'h4: s = 5'h0a;
      4'h5: s = 5'h0b;
      4'h6: s = 5'h0e;
      4'h7: s = 5'h0f;
      4'h8: s = 5'h12;
      4'h9: s = 5'h13;
      4'ha: s = 5'h16;
      4'hb: s = 5'h17;
      4'hc: s = 5'h1a;
      4'hd: s = 5'h1b;
      4'he: s = 5'h1c;
      default: s = 5'h1d;
    endcase
    return s;
  endfunction : plsc_enc4

  // ten-bit command symbol for a nonzero command value
  function automatic logic [9:0] plsc_cmd_sym(input logic [3:0] c);
    logic [9:0] s;
    case (c)
      4'h1: s = 10'h3ff;
      4'h2: s = 10'h1ad;
      4'h3: s = 10'h1b9;
      4'h4: s = 10'h3e4;
      4'h5: s = 10'h1a7;
      4'h6: s = 10'h327;
      4'h7: s = 10'h339;
      4'h8: s = 10'h084;
      4'h9: s = 10'h09f;
      4'ha: s = 10'h080;
      4'hb: s = 10'h0e7;
      4'hc: s = 10'h0f9;
      4'hd: s = 10'h004;
      4'he: s = 10'h01f;
      default: s = 10'h000;
    endcase
    return s;
  endfunction : plsc_cmd_sym

endpackage : plsc_pkg

//--- testbench/plsc_host_model.sv
// host bus model: presents words through the load strobe handshake
`timescale 1ns/1ps
`default_nettype none
module plsc_host_model
  import plsc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       word_ack,
  output var  logic [9:0] data_in,
  output var  logic [3:0] cmd_in,
  output var  logic       word_load_strobe
);
  initial begin
    data_in = 10'h000;
    cmd_in = 4'h0;
    word_load_strobe = 1'b0;
  end

  // the task lets one edge pass before raising the strobe, so it is low for a cycle between calls
  task automatic send(input logic [9:0] d, input logic [3:0] c, input int stall, output bit ok);
    int n;
    ok = 1'b0;
    repeat (stall) @(posedge clk);
    @(posedge clk);
    #1;
    data_in = d;
    cmd_in = c;
    word_load_strobe = 1'b1;
    for (n = 0; n < 200 && !ok; n++) begin
      @(posedge clk);
      ok = (word_ack === 1'b1);
    end
    #1;
    word_load_strobe = 1'b0;
    // released lines must not keep showing the last word
    data_in = ~d;
    cmd_in = ~c;
  endtask : send
endmodule : plsc_host_model
`default_nettype wire

//--- testbench/plsc_link_codec_checker.sv
// concurrent checks on the ports of the link codec
`timescale 1ns/1ps
`default_nettype none
module plsc_link_codec_checker
  import plsc_pkg::*;
(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       word_load_strobe,
  input wire logic       word_ack,
  input wire logic       serial_out,
  input wire logic [9:0] data_out,
  input wire logic [3:0] cmd_out,
  input wire logic       word_out_strobe,
  input wire logic       word_out_is_cmd,
  input wire logic       rx_aligned
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ---------------------------------------------------------------
  // load side
  // ---------------------------------------------------------------
  ack_pulse_a: assert property (word_ack |=> !word_ack) else $error("acknowledge wider than one cycle");
  ack_cause_a: assert property ($rose(word_ack) |-> $past(word_load_strobe)) else $error("unprompted ack");
  // a waiting word must be taken within 150 clocks: about two byte periods in test mode, over three otherwise
  ack_bound_a: assert property ($rose(word_load_strobe) |-> ##[1:150] word_ack) else $error("ack too late");

  // ---------------------------------------------------------------
  // line and receive side
  // ---------------------------------------------------------------
  line_run_a: assert property ($changed(serial_out) |=> $stable(serial_out)[*3]) else $error("bit too short");
  stb_pulse_a: assert property (word_out_strobe |=> !word_out_strobe) else $error("strobe too wide");
  sync_hold_a: assert property (!word_out_strobe |-> $stable(data_out) && $stable(cmd_out))
    else $error("outputs moved without strobe");
  stb_aligned_a: assert property (word_out_strobe |-> rx_aligned) else $error("word while unaligned");
  cmd_keeps_data_a: assert property (word_out_strobe && word_out_is_cmd |-> $stable(data_out))
    else $error("command disturbed data");
  data_clears_cmd_a: assert property (word_out_strobe && !word_out_is_cmd |-> cmd_out == 4'h0)
    else $error("data word left command set");

  data_seen_c: cover property (word_out_strobe && !word_out_is_cmd);
  cmd_seen_c: cover property (word_out_strobe && word_out_is_cmd);
  align_seen_c: cover property ($rose(rx_aligned));
endmodule : plsc_link_codec_checker
`default_nettype wire

//--- testbench/tb_plsc_link_codec.sv
// self-checking bench: host model on the parallel side, serial line looped back
`timescale 1ns/1ps
`default_nettype none
bind plsc_link_codec plsc_link_codec_checker plsc_link_codec_checker_inst (
  .clk(clk), .reset(reset), .word_load_strobe(word_load_strobe), .word_ack(word_ack),
  .serial_out(serial_out), .data_out(data_out), .cmd_out(cmd_out), .word_out_strobe(word_out_strobe),
  .word_out_is_cmd(word_out_is_cmd), .rx_aligned(rx_aligned)
);

module tb_plsc_link_codec
  import plsc_pkg::*;
;
  logic        clk;
  logic        reset;
  logic [1:0]  width_sel;
  logic [9:0]  data_in;
  logic [3:0]  cmd_in;
  logic        word_load_strobe;
  logic        word_ack;
  logic        serial_line;
  logic [9:0]  data_out;
  logic [3:0]  cmd_out;
  logic        word_out_strobe;
  logic        word_out_is_cmd;
  logic        rx_aligned;
  logic        test_mode;
  logic        tx_ext_bit_clk;
  logic        rx_ext_bit_clk;
  logic [2:0]  ext_div = 3'h0;
  int          errors;
  int          checks_done;
  int          seed;
  int          nd;
  int          nc;
  logic [9:0]  last_data;
  logic [14:0] exp_q[$];

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // test-mode bit clocks, eight clocks a bit; the receive clock rises mid-bit,
  // which leaves room for the pin synchronisers on both sides
  always @(posedge clk) ext_div <= ext_div + 3'h1;
  assign tx_ext_bit_clk = ext_div[2];
  assign rx_ext_bit_clk = ~ext_div[2];

  plsc_host_model plsc_host_model_inst (
    .clk(clk), .word_ack(word_ack), .data_in(data_in), .cmd_in(cmd_in), .word_load_strobe(word_load_strobe)
  );

  plsc_link_codec plsc_link_codec_inst (
    .clk(clk), .reset(reset), .width_sel(width_sel), .test_mode(test_mode),
    .tx_ext_bit_clk(tx_ext_bit_clk), .rx_ext_bit_clk(rx_ext_bit_clk), .data_in(data_in), .cmd_in(cmd_in),
    .word_load_strobe(word_load_strobe), .word_ack(word_ack), .serial_out(serial_line),
    .serial_in(serial_line), .data_out(data_out), .cmd_out(cmd_out), .word_out_strobe(word_out_strobe),
    .word_out_is_cmd(word_out_is_cmd), .rx_aligned(rx_aligned)
  );

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input logic [14:0] seen, input logic [14:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("ERROR %0t: seen %h, expected %h", $time, seen, want);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // every strobe must match the oldest word still owed; a sync-made strobe finds none
  always @(negedge clk) begin
    if (reset === 1'b0 && word_out_strobe === 1'b1) begin
      check(15'(exp_q.size() != 0), 15'h0001);
      if (exp_q.size() != 0) begin
        check({word_out_is_cmd, cmd_out, data_out}, exp_q.pop_front());
      end
    end
  end

  // ---------------------------------------------------------------
  // drivers
  // ---------------------------------------------------------------
  task automatic do_reset(input logic [1:0] w, input logic tm);
    @(posedge clk);
    #1;
    reset = 1'b1;
    width_sel = w;
    test_mode = tm;
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    last_data = 10'h000;
  endtask : do_reset

  task automatic send_word(input logic [9:0] d, input logic [3:0] c, input int stall);
    logic [9:0] dm;
    logic [3:0] cm;
    bit         ack_ok;
    dm = d & ((10'h001 << nd) - 10'h001);
    cm = c & ((4'h1 << nc) - 4'h1);
    if (cm != 4'h0) begin
      exp_q.push_back({1'b1, cm, last_data});
    end else begin
      exp_q.push_back({1'b0, 4'h0, dm});
      last_data = dm;
    end
    plsc_host_model_inst.send(d, c, stall, ack_ok);
    check(15'(ack_ok), 15'h0001);
  endtask : send_word

  task automatic wait_drained;
    int n;
    for (n = 0; n < 400 && exp_q.size() != 0; n++) @(negedge clk);
    check(15'(exp_q.size()), 15'h0000);
  endtask : wait_drained

  // ---------------------------------------------------------------
  // main sequence: every width, every command code, data edges, idle gaps
  // ---------------------------------------------------------------
  initial begin
    int w;
    int c;
    int k;
    int n;
    seed = 32'hb49f;
    errors = 0;
    checks_done = 0;
    reset = 1'b1;
    width_sel = 2'b00;
    last_data = 10'h000;
    nd = 8;
    nc = 4;
    test_mode = 1'b0;
    for (w = 0; w < 5; w++) begin
      // width 11 behaves as the ten-bit split; pass 4 repeats eight bits in test mode
      nd = (w % 4 == 0) ? 8 : (w % 4 == 1) ? 9 : 10;
      nc = 12 - nd;
      do_reset(2'(w), w == 4);
      for (n = 0; n < 600 && rx_aligned !== 1'b1; n++) @(negedge clk);
      check(15'(rx_aligned), 15'h0001);
      for (c = 1; c < (1 << nc); c++) begin
        send_word(10'($random(seed)), 4'(c), 0);
      end
      send_word(10'h000, 4'h0, 0);
      send_word(10'h3ff, 4'h0, 0);
      for (k = 0; k < 6; k++) begin
        send_word(10'($random(seed)), 4'h0, int'($random(seed) & 3));
      end
      send_word(10'($random(seed)), 4'(1), 60);
      wait_drained;
      repeat (200) @(posedge clk);
      // only syncs since the last command: it and the data before it must survive
      check({word_out_is_cmd, cmd_out, data_out}, {1'b1, 4'h1, last_data});
    end
    close_out;
  end

  initial begin
    #(25.0 * 60000);
    errors++;
    close_out;
  end
endmodule : tb_plsc_link_codec
`default_nettype wire
